// file: include/seb_pkg.sv
package seb_pkg;
	// organization and array
	localparam int ADDR_W16 = 6;
	localparam int ADDR_W8 = 7;
	localparam int WORDS_X16 = 64;
	localparam int WORD_BITS = 16;
	localparam int ARRAY_BITS = WORDS_X16 * WORD_BITS;
	// pin order in the synchroniser bank
	localparam int N_PINS = 4;
	localparam int PIN_CS = 0;
	localparam int PIN_SK = 1;
	localparam int PIN_DI = 2;
	localparam int PIN_ORG = 3;
	// command frame
	localparam logic [1:0] OP_EXT = 2'h0;
	localparam logic [1:0] SUB_DISABLE = 2'h0;
	localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
	localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
	localparam logic [1:0] SUB_ENABLE = 2'h3;
	localparam logic [4:0] HDR_BITS_X16 = 5'h09;
	localparam logic [4:0] HDR_BITS_X8 = 5'h0a;
	localparam logic [4:0] DATA_BITS_X16 = 5'h10;
	localparam logic [4:0] DATA_BITS_X8 = 5'h08;
	localparam logic [4:0] FIELD_CNT_W = 5'h1f;
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int BULK_TIME_US = 100;
	localparam int BULK_CYCLES = (BULK_TIME_US * (CLK_HZ / 1_000_000) > 0) ?
		BULK_TIME_US * (CLK_HZ / 1_000_000) : 1;
	localparam int TIMER_W = 12;
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 12'h000;
	// erased state of a cell
	localparam logic [WORD_BITS-1:0] ERASED_WORD = 16'hffff;
	typedef enum logic [2:0] {
		SEB_IDLE,
		SEB_HEADER,
		SEB_DATA,
		SEB_ARMED,
		SEB_IGNORE,
		SEB_BUSY
	} seb_state_e;
endpackage

// file: src/seb_bulk.sv
// Functional notes
// - the chip select fall after a full erase-all command starts a timed clear of the array.
// - a finished erase-all leaves every array bit at 1.
// - the chip select fall after a full write-all frame stores its word in every location.
// - a started bulk cycle runs to the end on the block clock with no serial clock needed.
// - while selected during a bulk cycle the output pin shows busy or ready.
// - write-all needs no prior erase; the cycle clears and writes internally.
// - a frame is start bit 1, two opcode bits, six address bits (seven in x8), then data.
// - the status bit is low while the cycle runs and high once ready.
// - bulk commands run only after write enable and before any write disable.
`timescale 1ns/1ps
module seb_bulk
	import seb_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic chip_select_in,
	input wire logic serial_clock_in,
	input wire logic serial_in_in,
	input wire logic word_width_select_in,
	output logic serial_out_out,
	output logic serial_out_oe_out,
	output logic busy_out,
	output logic write_enabled_out
);
	logic cs_s;
	logic sk_s;
	logic di_s;
	logic org_s;
	logic [N_PINS-1:0] pin_raw;
	wire logic [N_PINS-1:0] pin_s;

	// every pin crosses into clk_in through two flops; order follows the pin indices
	assign pin_raw = {word_width_select_in, serial_in_in, serial_clock_in, chip_select_in};
	for (genvar p = 0; p < N_PINS; p++) begin : g_sync
		seb_sync u_sync (
			.clk_in(clk_in),
			.rstn_in(rstn_in),
			.async_in(pin_raw[p]),
			.sync_out(pin_s[p])
		);
	end
	assign cs_s = pin_s[PIN_CS];
	assign sk_s = pin_s[PIN_SK];
	assign di_s = pin_s[PIN_DI];
	assign org_s = pin_s[PIN_ORG];

	typedef struct packed {
		seb_state_e state;
		logic cs_d;
		logic sk_d;
		logic [4:0] cnt;
		logic [1:0] op;
		logic [6:0] addr;
		logic [WORD_BITS-1:0] data;
		logic [WORD_BITS-1:0] fill;
		logic [1:0] pend;
		logic wen;
		logic x8;
		logic [TIMER_W-1:0] timer;
		logic do_val;
		logic do_oe;
		logic status_on;
		logic poll;
		logic busy;
	} seb_s;

	seb_s cur_reg;
	seb_s cur_next;
	logic [WORD_BITS-1:0] mem [WORDS_X16];

	function automatic logic [1:0] sub_code(input logic [6:0] a, input logic x8);
		sub_code = x8 ? a[6:5] : a[5:4];
	endfunction

	// bit count of a header or data field for the selected organisation
	function automatic logic [4:0] field_len(input logic is_hdr, input logic x8);
		if (is_hdr) begin
			field_len = x8 ? HDR_BITS_X8 : HDR_BITS_X16;
		end else begin
			field_len = x8 ? DATA_BITS_X8 : DATA_BITS_X16;
		end
	endfunction

	function automatic logic edge_seen(input logic now_v, input logic was_v);
		edge_seen = now_v && !was_v;
	endfunction

	logic sk_rise;
	logic cs_rise;
	logic cs_fall;
	logic [4:0] hdr_len;
	logic [4:0] dat_len;
	logic mem_write;
	assign sk_rise = edge_seen(sk_s, cur_reg.sk_d);
	assign cs_rise = edge_seen(cs_s, cur_reg.cs_d);
	assign cs_fall = edge_seen(!cs_s, !cur_reg.cs_d);
	assign hdr_len = field_len(1'h1, cur_reg.x8);
	assign dat_len = field_len(1'h0, cur_reg.x8);

	always_comb begin
		cur_next = cur_reg;
		mem_write = 1'b0;
		cur_next.cs_d = cs_s;
		cur_next.sk_d = sk_s;
		case (cur_reg.state)
			SEB_IDLE: begin
				if (cs_s && sk_rise && di_s) begin
					cur_next.state = SEB_HEADER;
					cur_next.cnt = 5'h01;
					cur_next.x8 = !org_s;
					cur_next.op = 2'h0;
					cur_next.addr = 7'h00;
					cur_next.data = '0;
				end
			end
			SEB_HEADER: begin
				if (!cs_s) begin
					cur_next.state = SEB_IDLE;
				end else if (sk_rise) begin
					if (cur_reg.cnt < 5'h03) begin
						cur_next.op = {cur_reg.op[0], di_s};
					end else begin
						cur_next.addr = {cur_reg.addr[5:0], di_s};
					end
					cur_next.cnt = cur_reg.cnt + 5'h01;
					if (cur_reg.cnt + 5'h01 == hdr_len) begin
						cur_next.cnt = 5'h00;
						cur_next.state = SEB_IGNORE;
						if (cur_reg.op == OP_EXT) begin
							case (sub_code({cur_reg.addr[5:0], di_s}, cur_reg.x8))
								SUB_ENABLE: cur_next.wen = 1'b1;
								SUB_DISABLE: cur_next.wen = 1'b0;
								SUB_ERASE_ALL: begin
									cur_next.pend = SUB_ERASE_ALL;
									cur_next.state = cur_reg.wen ? SEB_ARMED : SEB_IGNORE;
								end
								SUB_WRITE_ALL: cur_next.state = SEB_DATA;
								default: cur_next.state = SEB_IGNORE;
							endcase
						end
					end
				end
			end
			SEB_DATA: begin
				if (!cs_s) begin
					cur_next.state = SEB_IDLE;
				end else if (sk_rise) begin
					cur_next.data = {cur_reg.data[WORD_BITS-2:0], di_s};
					cur_next.cnt = cur_reg.cnt + 5'h01;
					if (cur_reg.cnt + 5'h01 == dat_len) begin
						cur_next.pend = SUB_WRITE_ALL;
						cur_next.state = cur_reg.wen ? SEB_ARMED : SEB_IGNORE;
					end
				end
			end
			SEB_ARMED: begin
				if (cs_fall) begin
					cur_next.state = SEB_BUSY;
					cur_next.timer = TIMER_W'(BULK_CYCLES);
					cur_next.poll = 1'h1;
					cur_next.cnt = 5'h00;
					if (cur_reg.pend == SUB_ERASE_ALL) begin
						cur_next.fill = ERASED_WORD;
					end else if (cur_reg.x8) begin
						cur_next.fill = {cur_reg.data[7:0], cur_reg.data[7:0]};
					end else begin
						cur_next.fill = cur_reg.data;
					end
				end else if (sk_rise) begin
					cur_next.state = SEB_IGNORE;
				end
			end
			SEB_IGNORE: begin
				if (!cs_s) begin
					cur_next.state = SEB_IDLE;
				end
			end
			SEB_BUSY: begin
				// self timed on clk_in; serial clock is not watched here
				mem_write = 1'b1;
				cur_next.timer = cur_reg.timer - TIMER_W'(1);
				if (cur_reg.timer == TIMER_ZERO + TIMER_W'(1)) begin
					cur_next.state = SEB_IDLE;
					cur_next.pend = SUB_DISABLE;
				end
			end
			default: cur_next.state = SEB_IDLE;
		endcase
		// ready/busy shown on the output while selected, only once a launch armed the poll
		// a dummy one shifted in while ready ends the poll and floats the pin
		if (!cs_s) begin
			cur_next.status_on = 1'h0;
		end else if (cs_rise) begin
			cur_next.status_on = cur_next.poll;
		end else if (sk_rise && di_s && cur_next.state != SEB_BUSY) begin
			cur_next.status_on = 1'h0;
			cur_next.poll = 1'h0;
		end
		cur_next.do_oe = cur_next.status_on && cs_s;
		cur_next.do_val = cur_next.state != SEB_BUSY;
		cur_next.busy = cur_next.state == SEB_BUSY;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// array fill: every word rewritten on each clock of the busy window
	always_ff @(posedge clk_in) begin
		if (mem_write) begin
			for (int i = 0; i < WORDS_X16; i++) begin
				mem[i] <= cur_reg.fill;
			end
		end
	end

	assign serial_out_out = cur_reg.do_val;
	assign serial_out_oe_out = cur_reg.do_oe;
	assign busy_out = cur_reg.busy;
	assign write_enabled_out = cur_reg.wen;
endmodule // seb_bulk

// file: src/seb_sync.sv
`timescale 1ns/1ps
module seb_sync (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_reg;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // seb_sync

// file: verif/seb_bulk_props.sv
`timescale 1ns/1ps
module seb_bulk_props
	import seb_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic chip_select_in,
	input wire logic serial_clock_in,
	input wire logic serial_in_in,
	input wire logic word_width_select_in,
	input wire logic serial_out_out,
	input wire logic serial_out_oe_out,
	input wire logic busy_out,
	input wire logic write_enabled_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	logic [TIMER_W-1:0] busy_run;
	// counts busy cycles so the full cycle length is checked without a long delay range
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			busy_run <= TIMER_ZERO;
		end else if (busy_out) begin
			busy_run <= busy_run + TIMER_W'(1);
		end else begin
			busy_run <= TIMER_ZERO;
		end
	end
	AST_START: assert property ($rose(busy_out) |->
		!chip_select_in && !$past(chip_select_in, 2)) else $error("start while selected");
	AST_LENGTH: assert property ($fell(busy_out) |->
		busy_run == TIMER_W'(BULK_CYCLES)) else $error("bulk length");
	AST_LENGTH_MAX: assert property (busy_out |->
		busy_run < TIMER_W'(BULK_CYCLES)) else $error("bulk overrun");
	AST_NEED_EN: assert property ($rose(busy_out) |->
		$past(write_enabled_out)) else $error("start while disabled");
	AST_EN_HELD: assert property (busy_out |-> write_enabled_out)
		else $error("enable lost in cycle");
	AST_BUSY_LOW: assert property (busy_out && serial_out_oe_out |->
		!serial_out_out) else $error("status high while busy");
	AST_READY_HIGH: assert property ($fell(busy_out) && serial_out_oe_out |->
		##[0:2] serial_out_out) else $error("status not ready");
	AST_POLL: assert property ((busy_out && chip_select_in)[*4] |->
		serial_out_oe_out) else $error("status not driven");
	AST_FLOAT: assert property ((!chip_select_in)[*4] |->
		!serial_out_oe_out) else $error("driven while deselected");
endmodule // seb_bulk_props
bind seb_bulk seb_bulk_props u_props (.clk_in, .rstn_in, .chip_select_in,
	.serial_clock_in, .serial_in_in, .word_width_select_in, .serial_out_out,
	.serial_out_oe_out, .busy_out, .write_enabled_out);

// file: verif/seb_bulk_tb.sv
`timescale 1ns/1ps
module seb_bulk_tb;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic ws = 1'h1;
	logic so, oe, busy, en, cs, sk, di;
	int n_mismatch = 0, n_compared = 0, cyc = 0;
	initial forever #50 clk = ~clk;
	seb_host h (.clk_in(clk), .cs_out(cs), .sk_out(sk), .di_out(di));
	seb_bulk dut (.clk_in(clk), .rstn_in(rstn), .chip_select_in(cs), .serial_clock_in(sk),
		.serial_in_in(di), .word_width_select_in(ws), .serial_out_out(so),
		.serial_out_oe_out(oe), .busy_out(busy), .write_enabled_out(en));
	task automatic chk(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// first and last word of the array after a bulk cycle
	task automatic chk_array(input logic [15:0] e);
		chk_word("word first", e, dut.mem[0]);
		chk_word("word last", e, dut.mem[seb_pkg::WORDS_X16-1]);
	endtask
	// selecting with no bulk cycle launched leaves the pin floating
	task automatic idle_select();
		h.sel(1'h1);
		repeat (5) @(negedge clk);
		chk("oe idle", 1'h0, oe);
		h.sel(1'h0);
		repeat (5) @(negedge clk);
	endtask
	// reset after a completed bulk cycle returns to the write-disabled state
	task automatic reset_run();
		rstn = 1'h0;
		repeat (2) @(negedge clk);
		rstn = 1'h1;
		repeat (4) @(negedge clk);
		chk("enabled", 1'h0, en);
		chk("oe", 1'h0, oe);
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	// one frame, then poll the status until the cycle ends
	task automatic bulk(input logic [24:0] bits, input int n, input logic go);
		int k;
		h.frame(bits, n);
		chk("busy", go, busy);
		if (go) begin
			h.sel(1'h1);
			repeat (5) @(negedge clk);
			chk("oe", 1'h1, oe);
			chk("status", 1'h0, so);
			k = 0;
			while (busy === 1'h1 && k < 1200) begin
				@(negedge clk);
				k++;
			end
			repeat (3) @(negedge clk);
			chk("status", 1'h1, so);
			h.sel(1'h0);
			repeat (5) @(negedge clk);
			chk("oe", 1'h0, oe);
		end
	endtask
	initial begin
		repeat (20) @(negedge clk);
		rstn = 1'h1;
		repeat (4) @(negedge clk);
		chk("enabled", 1'h0, en);
		chk("oe", 1'h0, oe);
		idle_select();
		bulk(25'h0000120, 9, 1'h0);
		bulk(25'h0000130, 9, 1'h0);
		chk("enabled", 1'h1, en);
		bulk(25'h0000120, 9, 1'h1);
		chk_array(seb_pkg::ERASED_WORD);
		bulk({9'h110, 16'ha55a}, 25, 1'h1);
		chk_array(16'ha55a);
		ws = 1'h0;
		bulk({7'h00, 10'h220, 8'h3c}, 18, 1'h1);
		chk_array(16'h3c3c);
		reset_run();
		idle_select();
		bulk(25'h0000260, 10, 1'h0);
		chk("enabled", 1'h1, en);
		bulk(25'h0000200, 10, 1'h0);
		chk("enabled", 1'h0, en);
		ws = 1'h1;
		bulk({9'h110, 16'h0f0f}, 25, 1'h0);
		chk_array(16'h3c3c);
		print_verdict();
	end
endmodule // seb_bulk_tb

// file: verif/seb_host.sv
`timescale 1ns/1ps
module seb_host (
	input wire logic clk_in,
	output logic cs_out,
	output logic sk_out,
	output logic di_out
);
	initial begin
		cs_out = 1'h0;
		sk_out = 1'h0;
		di_out = 1'h0;
	end
	task automatic sel(input logic v);
		cs_out = v;
	endtask
	// clock stands still outside frames; data inverted once the frame ends
	task automatic frame(input logic [24:0] bits, input int n);
		cs_out = 1'h1;
		for (int i = n - 1; i >= 0; i--) begin
			di_out = bits[i];
			repeat (4) @(negedge clk_in);
			sk_out = 1'h1;
			repeat (4) @(negedge clk_in);
			sk_out = 1'h0;
		end
		di_out = ~di_out;
		repeat (4) @(negedge clk_in);
		cs_out = 1'h0;
		repeat (8) @(negedge clk_in);
	endtask
endmodule // seb_host
